/* hdl/dtxhp_pkg.sv */
// Purpose: shared constants for the tone transceiver host port
// Assumes: 100 MHz system clock, 4-bit parallel bus
// Notes:   register indices and bit positions are local choices
package dtxhp_pkg;
	localparam int          DTXHP_DW         = 4;
	// register select values
	localparam logic        DTXHP_RS_DATA    = 1'h0;
	localparam logic        DTXHP_RS_CTRL    = 1'h1;
	// control register bits (write, register select high)
	localparam int          DTXHP_B_RXDIS    = 0;
	localparam int          DTXHP_B_TXDIS    = 1;
	localparam int          DTXHP_B_CPMODE   = 2;
	localparam int          DTXHP_B_BURST    = 3;
	// status register bits (read, register select high)
	localparam int          DTXHP_B_IRQ      = 0;
	localparam int          DTXHP_B_TXDONE   = 1;
	localparam int          DTXHP_B_DSTEER   = 2;
	localparam int          DTXHP_B_PWRDN    = 3;
	localparam logic [3:0]  DTXHP_CTRL_RST   = 4'h0;
	localparam logic [3:0]  DTXHP_CODE_D     = 4'h0;
	// reference clock and burst timing
	localparam real         DTXHP_REF_MHZ    = 3.579545;
	localparam real         DTXHP_SYS_MHZ    = 100.0;
	localparam real         DTXHP_BURST_MS   = 51.0;
	localparam int          DTXHP_BURST_CYC  = int'(DTXHP_BURST_MS * 1000.0 * DTXHP_SYS_MHZ);
	localparam int          DTXHP_SETTLE_CYC = 4;
	localparam int          DTXHP_SYNC_LEN   = 3;
endpackage : dtxhp_pkg

/* hdl/dtxhp_bus_if.sv */
// Purpose: wires joining host and device ends of the tone transceiver port
// Assumes: all signals synchronous to one clock at the bench
// Notes:   open-drain and three-state levels resolved here from enables
`timescale 1ns/1ps
interface dtxhp_bus_if;
	logic       cs_n;
	logic       register_select_line;
	logic       rw_wr;
	logic       data_strobe_in;
	logic       strobe_mode;
	logic [3:0] host_d;
	logic       host_d_oe;
	logic [3:0] dev_d;
	logic       dev_d_oe;
	logic       irq_drive_low;
	logic [3:0] data_bus;
	logic       interrupt_or_callprog_n;

	// bus resolution; the device side wins only when it drives
	assign data_bus = dev_d_oe ? dev_d : (host_d_oe ? host_d : 4'hF);
	// open drain with pull-up
	assign interrupt_or_callprog_n = ~irq_drive_low;

	modport device_mp (
		input  cs_n, register_select_line, rw_wr, data_strobe_in, strobe_mode, data_bus,
		output dev_d, dev_d_oe, irq_drive_low
	);
	modport host_mp (
		input  data_bus, interrupt_or_callprog_n,
		output cs_n, register_select_line, rw_wr, data_strobe_in, strobe_mode,
		       host_d, host_d_oe
	);
endinterface : dtxhp_bus_if

/* hdl/dtxhp_device.sv */
// Purpose: digital side of the tone transceiver behind its 4-bit host port
// Assumes: bus pins asynchronous to mclk_in, synchronised by three flops
// Notes:   analog blocks are modelled by digital inputs and outputs
`timescale 1ns/1ps
module dtxhp_device
	import dtxhp_pkg::*;
#(
	parameter int BURST_CYC  = DTXHP_BURST_CYC,
	parameter int SETTLE_CYC = DTXHP_SETTLE_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	dtxhp_bus_if.device_mp   bus,
	input  wire logic        tone_valid_in,
	input  wire logic [3:0]  tone_code_in,
	input  wire logic        steer_in,
	input  wire logic        callprog_sq_in,
	output logic             early_steer_out,
	output logic             guard_time_out,
	output logic [3:0]       tx_code_out,
	output logic             tone_on_out,
	output logic             tone_oe_out,
	output logic             rx_powered_out,
	output logic             osc_run_out
);
	initial begin
		if (BURST_CYC < 1 || SETTLE_CYC < 1 || SETTLE_CYC > 255)
			$error("dtxhp_device: counts must be positive");
	end

	////////////////////////////////////////////////////////////////////////
	// three-flop synchronisers for pin inputs
	logic [DTXHP_SYNC_LEN-1:0] cs_s_q, rs_s_q, rw_s_q, ds_s_q, st_s_q, ev_s_q;
	logic [DTXHP_SYNC_LEN-1:0] cp_s_q, md_s_q;
	logic [3:0]                d_s1_q, d_s2_q, d_s3_q, d_q;
	logic [3:0]                tc_s1_q, tc_s2_q, tc_s3_q, tc_q;
	logic                      cs_n_q, rs_q, rw_q, ds_q, st_q, ev_q, cp_q, md_q;

	function automatic logic dtxhp_filt(input logic [2:0] s, input logic prev);
		return (s[1] == s[2]) ? s[2] : prev;
	endfunction : dtxhp_filt

	always_ff @(posedge mclk_in) begin
		cs_s_q <= {cs_s_q[1:0], bus.cs_n};
		rs_s_q <= {rs_s_q[1:0], bus.register_select_line};
		rw_s_q <= {rw_s_q[1:0], bus.rw_wr};
		ds_s_q <= {ds_s_q[1:0], bus.data_strobe_in};
		st_s_q <= {st_s_q[1:0], steer_in};
		ev_s_q <= {ev_s_q[1:0], tone_valid_in};
		cp_s_q <= {cp_s_q[1:0], callprog_sq_in};
		md_s_q <= {md_s_q[1:0], bus.strobe_mode};
		d_s1_q <= bus.data_bus;
		d_s2_q <= d_s1_q;
		d_s3_q <= d_s2_q;
		tc_s1_q <= tone_code_in;
		tc_s2_q <= tc_s1_q;
		tc_s3_q <= tc_s2_q;
	end

	// settled levels: second and third stage must agree
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			{cs_n_q, rs_q, rw_q, ds_q} <= 4'hD;
			{st_q, ev_q, cp_q, md_q}   <= 4'h1;
			d_q                        <= 4'h0;
			tc_q                       <= DTXHP_CODE_D;
		end else begin
			// nibbles settle like the single-bit pins
			d_q    <= (d_s2_q == d_s3_q) ? d_s3_q : d_q;
			tc_q   <= (tc_s2_q == tc_s3_q) ? tc_s3_q : tc_q;
			cs_n_q <= dtxhp_filt(cs_s_q, cs_n_q);
			rs_q   <= dtxhp_filt(rs_s_q, rs_q);
			rw_q   <= dtxhp_filt(rw_s_q, rw_q);
			ds_q   <= dtxhp_filt(ds_s_q, ds_q);
			st_q   <= dtxhp_filt(st_s_q, st_q);
			ev_q   <= dtxhp_filt(ev_s_q, ev_q);
			cp_q   <= dtxhp_filt(cp_s_q, cp_q);
			md_q   <= dtxhp_filt(md_s_q, md_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus cycle decode; strobe mode: direction is a level, else a strobe
	wire sel      = ~cs_n_q;
	wire rd_act   = sel & (md_q ? (ds_q & rw_q) : ~ds_q);
	wire wr_act   = sel & (md_q ? (ds_q & ~rw_q) : ~rw_q);
	logic wr_act_q, rd_act_q;
	wire wr_end   = wr_act_q & ~wr_act;                      // latch data at strobe end
	wire rd_end   = rd_act_q & ~rd_act;

	logic [3:0] ctrl_q, tx_digit_q, rx_data_q;
	logic       txdone_q, dsteer_q;
	wire        rx_dis   = ctrl_q[DTXHP_B_RXDIS];
	wire        tx_dis   = ctrl_q[DTXHP_B_TXDIS];
	wire        cp_mode  = ctrl_q[DTXHP_B_CPMODE];
	wire        all_down = rx_dis & tx_dis;
	wire        irq_evt  = txdone_q | dsteer_q;
	wire [3:0]  status   = {all_down, dsteer_q, txdone_q, irq_evt};
	wire [3:0]  rd_word  = (rs_q == DTXHP_RS_CTRL) ? status : rx_data_q;
	wire        rd_st    = rd_end & (rs_q == DTXHP_RS_CTRL);
	wire        rd_dat   = rd_end & (rs_q == DTXHP_RS_DATA);

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			wr_act_q   <= 1'b0;
			rd_act_q   <= 1'b0;
			ctrl_q     <= DTXHP_CTRL_RST;
			tx_digit_q <= DTXHP_CODE_D;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			if (wr_end && rs_q == DTXHP_RS_CTRL)
				ctrl_q <= d_q;
			if (wr_end && rs_q == DTXHP_RS_DATA)
				tx_digit_q <= d_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// burst and pause timer; counts only while transmitter powered
	typedef enum logic [2:0] {
		DTXHP_T_IDLE  = 3'b001,
		DTXHP_T_TONE  = 3'b010,
		DTXHP_T_PAUSE = 3'b100
	} dtxhp_tx_t;
	dtxhp_tx_t  tx_st_q;
	logic [31:0] tcnt_q;
	wire        tx_start = wr_end & (rs_q == DTXHP_RS_DATA) & ~tx_dis;
	wire        tcnt_end = (tcnt_q == 32'(BURST_CYC - 1));

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			tx_st_q  <= DTXHP_T_IDLE;
			tcnt_q   <= '0;
			txdone_q <= 1'b0;
		end else begin
			tcnt_q <= (tx_st_q == DTXHP_T_IDLE || tcnt_end) ? '0 : tcnt_q + 32'h1;
			if (tx_dis) tx_st_q <= DTXHP_T_IDLE;
			else case (tx_st_q)
				DTXHP_T_IDLE:  if (tx_start) tx_st_q <= DTXHP_T_TONE;
				DTXHP_T_TONE:  if (tcnt_end) tx_st_q <= DTXHP_T_PAUSE;
				DTXHP_T_PAUSE: if (tcnt_end) tx_st_q <= DTXHP_T_IDLE;
				default:       tx_st_q <= DTXHP_T_IDLE;
			endcase
			// set beats a same-cycle clear by status read
			if (tx_st_q == DTXHP_T_TONE && tcnt_end && ctrl_q[DTXHP_B_BURST])
				txdone_q <= 1'b1;
			else if (rd_st)
				txdone_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// steering: latch code on steer rise, settle, then flag
	logic       st_prev_q;
	logic [7:0] settle_q;
	wire        st_rise = st_q & ~st_prev_q & ~rx_dis;

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			st_prev_q <= 1'b0;
			rx_data_q <= DTXHP_CODE_D;
			settle_q  <= '0;
			dsteer_q  <= 1'b0;
		end else begin
			st_prev_q <= st_q;
			if (st_rise)
				rx_data_q <= tc_q;
			settle_q <= st_rise ? 8'(SETTLE_CYC) : (settle_q != 8'h0 ? settle_q - 8'h1 : 8'h0);
			if (settle_q == 8'h1)
				dsteer_q <= 1'b1;
			else if (rd_dat || rx_dis)
				dsteer_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			early_steer_out <= 1'b0;
			guard_time_out  <= 1'b0;
			tx_code_out     <= DTXHP_CODE_D;
			tone_on_out     <= 1'b0;
			tone_oe_out     <= 1'b0;
			rx_powered_out  <= 1'b0;
			osc_run_out     <= 1'b0;
			bus.dev_d       <= 4'h0;
			bus.dev_d_oe    <= 1'b0;
			bus.irq_drive_low <= 1'b0;
		end else begin
			early_steer_out <= ev_q & ~rx_dis;
			guard_time_out  <= ev_q & st_q & ~rx_dis;
			tx_code_out     <= tx_digit_q;
			tone_on_out     <= (tx_st_q == DTXHP_T_TONE);
			tone_oe_out     <= ~tx_dis;
			rx_powered_out  <= ~rx_dis;
			osc_run_out     <= ~all_down;
			bus.dev_d       <= rd_word;
			bus.dev_d_oe    <= rd_act & ~all_down;
			bus.irq_drive_low <= all_down ? 1'b0 :
				(cp_mode ? ~cp_q : irq_evt);
		end
	end
endmodule : dtxhp_device

/* hdl/dtxhp_host.sv */
// Purpose: host end driving the 4-bit port from a simple command strobe
// Assumes: same mclk_in as device; device samples through synchronisers
// Notes:   each phase is held for PHASE_CYC clocks so the device sees it
`timescale 1ns/1ps
module dtxhp_host
	import dtxhp_pkg::*;
#(
	parameter int PHASE_CYC = 8
) (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	dtxhp_bus_if.host_mp     bus,
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_write_in,
	input  wire logic        cmd_rs_in,
	input  wire logic [3:0]  cmd_data_in,
	input  wire logic        cmd_strobe_mode_in,
	output logic             cmd_ready_out,
	output logic             rd_valid_out,
	output logic [3:0]       rd_data_out,
	output logic             irq_out
);
	initial begin
		if (PHASE_CYC < 4 || PHASE_CYC > 255)
			$error("dtxhp_host: PHASE_CYC out of range");
	end

	typedef enum logic [3:0] {
		DTXHP_H_IDLE  = 4'b0001,
		DTXHP_H_SETUP = 4'b0010,
		DTXHP_H_STRB  = 4'b0100,
		DTXHP_H_HOLD  = 4'b1000
	} dtxhp_h_t;
	dtxhp_h_t   st_q;
	logic [7:0] cnt_q;
	logic       wr_q, md_q;
	logic [1:0] irq_s_q;
	wire        cnt_end = (cnt_q == 8'(PHASE_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// access sequencer: select, strobe, release
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			st_q <= DTXHP_H_IDLE;
			cnt_q <= '0;
			wr_q <= 1'b0;
			md_q <= 1'b1;
			cmd_ready_out <= 1'b1;
			rd_valid_out <= 1'b0;
			rd_data_out <= 4'h0;
			bus.cs_n <= 1'b1;
			bus.register_select_line <= 1'b0;
			bus.rw_wr <= 1'b1;
			bus.data_strobe_in <= 1'b0;
			bus.strobe_mode <= 1'b1;
			bus.host_d <= 4'h0;
			bus.host_d_oe <= 1'b0;
		end else begin
			rd_valid_out <= 1'b0;
			cnt_q <= (st_q == DTXHP_H_IDLE || cnt_end) ? 8'h0 : cnt_q + 8'h1;
			case (st_q)
				DTXHP_H_IDLE: if (cmd_valid_in) begin
					st_q <= DTXHP_H_SETUP;
					cmd_ready_out <= 1'b0;
					wr_q <= cmd_write_in;
					md_q <= cmd_strobe_mode_in;
					bus.strobe_mode <= cmd_strobe_mode_in;
					bus.cs_n <= 1'b0;
					bus.register_select_line <= cmd_rs_in;
					bus.host_d <= cmd_data_in;
					bus.host_d_oe <= cmd_write_in;
					bus.rw_wr <= cmd_strobe_mode_in ? ~cmd_write_in : 1'b1;
					bus.data_strobe_in <= ~cmd_strobe_mode_in;
				end
				DTXHP_H_SETUP: if (cnt_end) begin
					st_q <= DTXHP_H_STRB;
					if (md_q) bus.data_strobe_in <= 1'b1;
					else if (wr_q) bus.rw_wr <= 1'b0;
					else bus.data_strobe_in <= 1'b0;
				end
				DTXHP_H_STRB: if (cnt_end) begin
					st_q <= DTXHP_H_HOLD;
					rd_data_out <= bus.data_bus;
					rd_valid_out <= ~wr_q;
					bus.data_strobe_in <= ~md_q;
					bus.rw_wr <= 1'b1;
				end
				DTXHP_H_HOLD: if (cnt_end) begin
					st_q <= DTXHP_H_IDLE;
					cmd_ready_out <= 1'b1;
					bus.cs_n <= 1'b1;
					bus.host_d_oe <= 1'b0;
				end
				default: st_q <= DTXHP_H_IDLE;
			endcase
		end
	end

	// interrupt line sampled as an outside level
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			irq_s_q <= 2'h0;
			irq_out <= 1'b0;
		end else begin
			irq_s_q <= {irq_s_q[0], ~bus.interrupt_or_callprog_n};
			irq_out <= irq_s_q[1];
		end
	end
endmodule : dtxhp_host

/* testbench/dtxhp_props.sv */
// Purpose: wire-level checks between host and device ends
// Assumes: one clock, synchronous active-low reset
// Notes:   repeat counts cover the three-flop input chains
`timescale 1ns/1ps
module dtxhp_props (
	input wire logic       mclk_in,
	input wire logic       resetn_in,
	input wire logic       cs_n,
	input wire logic       register_select_line,
	input wire logic       rw_wr,
	input wire logic       data_strobe_in,
	input wire logic       strobe_mode,
	input wire logic [3:0] dev_d,
	input wire logic       dev_d_oe,
	input wire logic [3:0] data_bus,
	input wire logic       tone_valid_in,
	input wire logic       steer_in,
	input wire logic       early_steer_out,
	input wire logic       guard_time_out,
	input wire logic       osc_run_out
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	////////////////////////////////
	// bus ownership; six cycles allow for the output enable lag
	a_float_desel: assert property (cs_n [*6] |-> !dev_d_oe)
		else $error("data bus driven while deselected");
	a_float_nostb: assert property ((strobe_mode && !data_strobe_in) [*6] |-> !dev_d_oe)
		else $error("data bus driven with strobe low");
	a_float_nord: assert property ((!strobe_mode && data_strobe_in) [*6] |-> !dev_d_oe)
		else $error("data bus driven with read high");
	a_drive_read: assert property ((!cs_n && strobe_mode && data_strobe_in && rw_wr
		&& osc_run_out) [*6] |-> dev_d_oe)
		else $error("selected read left the bus floating");
	a_device_wins: assert property (dev_d_oe |-> (data_bus == dev_d && !cs_n && rw_wr))
		else $error("device drove the bus outside a selected read");
	// host side: strobe only inside a qualified select
	a_strobe_qual: assert property ($rose(data_strobe_in) && strobe_mode |-> !cs_n)
		else $error("data strobe raised outside a select");
	a_rs_held: assert property (!cs_n && !$past(cs_n) |-> $stable(register_select_line))
		else $error("register select moved during an access");

	////////////////////////////////
	// steering outputs
	a_est_on: assert property (tone_valid_in [*6] |-> early_steer_out)
		else $error("early steer missing for valid pair");
	a_est_off: assert property (!tone_valid_in [*6] |-> !early_steer_out)
		else $error("early steer held after loss of pair");
	a_guard_low: assert property (!early_steer_out [*5] |-> !guard_time_out)
		else $error("guard high without early steer");
	a_guard_high: assert property ((early_steer_out && steer_in) [*6] |-> guard_time_out)
		else $error("guard low with steer and early steer");
endmodule : dtxhp_props

/* testbench/testbench.sv */
// Purpose: directed bench joining host and device ends of the port
// Assumes: 100 MHz clock, burst count cut to keep the run short
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench
	import dtxhp_pkg::*;
;
	localparam int BURST = 20;
	logic       mclk_in;
	logic       resetn_in;
	logic       cmd_valid_in;
	logic       cmd_write_in;
	logic       cmd_rs_in;
	logic [3:0] cmd_data_in;
	logic       cmd_strobe_mode_in;
	logic       cmd_ready_out;
	logic       rd_valid_out;
	logic [3:0] rd_data_out;
	logic       irq_out;
	logic       tone_valid_in;
	logic [3:0] tone_code_in;
	logic       steer_in;
	logic       callprog_sq_in;
	logic       early_steer_out;
	logic       guard_time_out;
	logic [3:0] tx_code_out;
	logic       tone_on_out;
	logic       tone_oe_out;
	logic       rx_powered_out;
	logic       osc_run_out;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         cyc = 0;
	int         tone_cyc = 0;

	////////////////////////////////
	dtxhp_bus_if bus_if ();
	dtxhp_device #(.BURST_CYC(BURST)) u_dtxhp_device (.mclk_in, .resetn_in, .bus(bus_if),
		.tone_valid_in, .tone_code_in, .steer_in, .callprog_sq_in, .early_steer_out,
		.guard_time_out, .tx_code_out, .tone_on_out, .tone_oe_out, .rx_powered_out,
		.osc_run_out);
	dtxhp_host u_dtxhp_host (.mclk_in, .resetn_in, .bus(bus_if), .cmd_valid_in,
		.cmd_write_in, .cmd_rs_in, .cmd_data_in, .cmd_strobe_mode_in, .cmd_ready_out,
		.rd_valid_out, .rd_data_out, .irq_out);
	dtxhp_props u_props (.mclk_in, .resetn_in, .cs_n(bus_if.cs_n),
		.register_select_line(bus_if.register_select_line), .rw_wr(bus_if.rw_wr),
		.data_strobe_in(bus_if.data_strobe_in), .strobe_mode(bus_if.strobe_mode),
		.dev_d(bus_if.dev_d), .dev_d_oe(bus_if.dev_d_oe), .data_bus(bus_if.data_bus),
		.tone_valid_in, .steer_in, .early_steer_out, .guard_time_out, .osc_run_out);

	// clock, and a hang guard well above the expected run
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	// burst length seen from outside; the host hides the tone start
	always @(posedge mclk_in) begin
		if (tone_on_out === 1'b1)
			tone_cyc++;
	end

	////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : step
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one host command; read data caught from the one-cycle pulse
	task automatic access(input logic wr, input logic rs, input logic [3:0] wd,
		input logic md, output logic [3:0] rd);
		int n;
		n = 0;
		rd = 4'h0;
		while (cmd_ready_out !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		cmd_valid_in = 1'b1;
		cmd_write_in = wr;
		cmd_rs_in = rs;
		cmd_data_in = wd;
		cmd_strobe_mode_in = md;
		step(1);
		cmd_valid_in = 1'b0;
		n = 0;
		while (cmd_ready_out !== 1'b1 && n < 200) begin
			if (rd_valid_out === 1'b1)
				rd = rd_data_out;
			step(1);
			n++;
		end
		if (n == 200)
			error_cnt++;
	endtask : access

	////////////////////////////////
	// receive two digits; second proves the latch rearms on steer low
	task automatic t_rx();
		logic [3:0] r;
		tone_code_in = 4'h5;
		tone_valid_in = 1'b1;
		step(8);
		check(early_steer_out, 1'b1);
		steer_in = 1'b1;
		step(16);
		check(guard_time_out, 1'b1);
		check(irq_out, 1'b1);
		access(1'b0, DTXHP_RS_CTRL, 4'h0, 1'b1, r);
		check(r[DTXHP_B_DSTEER], 1'b1);
		access(1'b0, DTXHP_RS_DATA, 4'h0, 1'b0, r);
		check(r, 4'h5);
		step(8);
		check(irq_out, 1'b0);
		tone_valid_in = 1'b0;
		step(8);
		check(guard_time_out, 1'b0);
		steer_in = 1'b0;
		tone_code_in = 4'hA;
		tone_valid_in = 1'b1;
		step(8);
		steer_in = 1'b1;
		step(12);
		access(1'b0, DTXHP_RS_DATA, 4'h0, 1'b1, r);
		check(r, 4'hA);
		tone_valid_in = 1'b0;
		steer_in = 1'b0;
		$display("t_rx finished");
	endtask : t_rx
	// timed burst in burst mode, done flag and its clear on read
	task automatic t_burst();
		logic [3:0] r;
		int n;
		access(1'b1, DTXHP_RS_CTRL, 4'h8, 1'b1, r);
		tone_cyc = 0;
		access(1'b1, DTXHP_RS_DATA, 4'hC, 1'b0, r);
		n = 0;
		while (tone_on_out !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		check(tx_code_out, 4'hC);
		n = 0;
		while (tone_on_out === 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		check(8'(tone_cyc), 8'(BURST));
		step(8);
		check(irq_out, 1'b1);
		access(1'b0, DTXHP_RS_CTRL, 4'h0, 1'b1, r);
		check(r[DTXHP_B_TXDONE], 1'b1);
		access(1'b0, DTXHP_RS_CTRL, 4'h0, 1'b1, r);
		check(r[DTXHP_B_TXDONE], 1'b0);
		$display("t_burst finished");
	endtask : t_burst
	// call progress: pin pulled low while the square input is low
	task automatic t_cp();
		logic [3:0] r;
		access(1'b1, DTXHP_RS_CTRL, 4'h4, 1'b1, r);
		for (int i = 0; i < 4; i++) begin
			callprog_sq_in = i[0];
			step(8);
			check(irq_out, !i[0]);
		end
		$display("t_cp finished");
	endtask : t_cp
	// every disable pair; both set floats reads, so the host sees F
	task automatic t_pwr();
		logic [3:0] r;
		for (int i = 0; i < 4; i++) begin
			access(1'b1, DTXHP_RS_CTRL, {2'h0, i[1:0]}, 1'b1, r);
			access(1'b1, DTXHP_RS_DATA, 4'h3, 1'b1, r);
			step(8);
			check(rx_powered_out, !i[0]);
			check(osc_run_out, i != 3);
			if (i[1])
				check({tone_oe_out, tone_on_out}, 2'h0);
			else
				check(tone_oe_out, 1'b1);
			access(1'b0, DTXHP_RS_CTRL, 4'h0, 1'b1, r);
			check(r, (i == 3) ? 4'hF : 4'h0);
			step(40);
		end
		access(1'b1, DTXHP_RS_CTRL, 4'h0, 1'b1, r);
		$display("t_pwr finished");
	endtask : t_pwr

	////////////////////////////////
	// main sequence
	initial begin
		resetn_in = 1'b0;
		cmd_valid_in = 1'b0;
		cmd_write_in = 1'b0;
		cmd_rs_in = 1'b0;
		cmd_data_in = 4'h0;
		cmd_strobe_mode_in = 1'b1;
		tone_valid_in = 1'b0;
		tone_code_in = 4'h0;
		steer_in = 1'b0;
		callprog_sq_in = 1'b1;
		step(12);
		resetn_in = 1'b1;
		t_rx();
		t_burst();
		t_cp();
		t_pwr();
		end_sim();
	end
endmodule : testbench
